// File: logic/scan_result_input_image_framer.sv
// cyclic input image framer: result store, header snapshot, byte stream out, register port
`default_nettype none

// How it works
// - image is streamed out again on request while enabled; a request made while one waits shares its frame
// - compact image length clamped to 1..260 bytes
// - compact bytes: status, count, result flags, length
// - compact result data starts at byte 5
// - extended image length clamped to 1..264 bytes
// - extended bytes: status, acknowledge, fragments, count, flags, length
// - extended result data starts at byte 9
// - each new result inverts the toggle bit
module scan_result_input_image_framer
	import image_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [DATA_W-1:0] reg_rdata,
	// interrupt
	output logic irq,
	// result source
	input wire logic res_wr,
	input wire logic [7:0] res_waddr,
	input wire logic [7:0] res_wdata,
	input wire logic res_commit,
	input wire logic [15:0] res_length,
	input wire logic [7:0] res_count,
	input wire logic res_activation,
	input wire logic res_user_cmd,
	input wire logic res_more,
	input wire logic res_overflow,
	input wire logic res_wait_ack,
	output logic res_ready,
	// device state fields
	input wire logic [7:0] dev_status,
	input wire logic accept_evt,
	input wire logic reject_evt,
	input wire logic [ERR_W-1:0] err_code,
	input wire logic [7:0] frag_num,
	input wire logic [7:0] frag_rem,
	input wire logic [7:0] frag_size,
	// image stream to the controller
	input wire logic frame_req,
	input wire logic img_ready,
	output logic img_valid,
	output logic [7:0] img_data,
	output logic img_first,
	output logic img_last
);

	// all state but the two reset flops in one record, so a frame snapshot is just one more field of it
	typedef struct packed {
		run_type run;
		logic pend;
		logic [LEN_W-1:0] pos;
		logic [LEN_W-1:0] len;
		hdr_type hdr;
		logic [7:0] data;
		logic valid;
		logic first;
		logic last;
		logic res_ready;
		logic [15:0] r_len;
		logic [7:0] r_cnt;
		logic [FLG_W-1:0] r_flags;
		logic acc_t;
		logic rej_t;
		logic ctl_en;
		logic ctl_ext;
		logic [LEN_W-1:0] cfg_len;
		logic [IRQ_W-1:0] irq_st;
		logic [IRQ_W-1:0] irq_mask;
		logic irq;
		logic [DATA_W-1:0] rdata;
		logic [DATA_MAX-1:0][7:0] mem;
	} state_type;

	state_type q;
	state_type d;
	logic [1:0] rst_sync_q;
	logic rst_n;
	logic start_now;
	logic [LEN_W-1:0] frame_len;
	hdr_type live;
	logic [IRQ_W-1:0] evt;
	logic [IRQ_W-1:0] clr;
	logic [7:0] ack_byte;

	// next byte position; frames never outgrow the length field
	function automatic logic [LEN_W-1:0] step_pos(input logic [LEN_W-1:0] p, input logic [LEN_W-1:0] k);
		return LEN_W'(p + k);
	endfunction

	// control word as software reads it back
	function automatic logic [DATA_W-1:0] ctrl_word(input state_type s);
		logic [DATA_W-1:0] w;
		w = '0;
		w[CTL_EN_BIT] = s.ctl_en;
		w[CTL_EXT_BIT] = s.ctl_ext;
		return w;
	endfunction

	// state word: busy, new-result toggle, pending request and result count
	function automatic logic [DATA_W-1:0] state_word(input state_type s);
		logic [DATA_W-1:0] w;
		w = '0;
		w[ST_BUSY_BIT] = (s.run == RUN_SEND);
		w[ST_TOGGLE_BIT] = s.r_flags[FLG_NEW];
		w[ST_PEND_BIT] = s.pend;
		w[ST_COUNT_LSB +: 8] = s.r_cnt;
		return w;
	endfunction

	// interrupt line level for a status and mask pair
	function automatic logic irq_level(input logic [IRQ_W-1:0] st, input logic [IRQ_W-1:0] mask);
		return |(st & mask);
	endfunction

	pick_if pk ();

	image_byte_picker u_picker (
		.pk(pk.picker)
	);

	// reset is released through two flip-flops
	// the first flop may settle late, so only the second one is read
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// acknowledge byte: reserved bits 7, 3 and 2 stay zero
	always_comb begin
		ack_byte = 8'h00;
		ack_byte[ACK_ACCEPT] = q.acc_t;
		ack_byte[ACK_REJECT] = q.rej_t;
		ack_byte[ACK_ERR_LSB +: ERR_W] = err_code;
	end

	// header as it would be sent if a frame started now
	always_comb begin
		live.ext = q.ctl_ext;
		live.dev_status = dev_status;
		live.ack = ack_byte;
		live.frag_num = frag_num;
		live.frag_rem = frag_rem;
		live.frag_size = frag_size;
		live.count = q.r_cnt;
		live.flags = q.r_flags;
		live.res_len = q.r_len;
	end

	// a frame waits while the result store is being written, so it never mixes two results
	assign start_now = (q.run == RUN_IDLE) && q.pend && q.ctl_en && !res_wr && !res_commit;
	// a zero length still sends the device status byte
	assign frame_len = clamp_len(q.cfg_len, q.ctl_ext);

	// the header is frozen for the whole frame; the picker sees the live copy only at start
	assign pk.hdr = start_now ? live : q.hdr;
	assign pk.idx = start_now ? 9'h000 : step_pos(q.pos, 9'h001);
	// positions past the result are masked in the picker, not here
	assign pk.mem_byte = q.mem[pk.mem_idx];

	always_comb begin
		d = q;
		evt = '0;
		clr = '0;

		// register writes
		// the master never raises both strobes, so the two decodes stay independent
		if (reg_write) begin
			unique case (reg_addr)
				OFS_CTRL: begin
					d.ctl_en = reg_wdata[CTL_EN_BIT];
					d.ctl_ext = reg_wdata[CTL_EXT_BIT];
				end
				OFS_LEN: d.cfg_len = reg_wdata[LEN_W-1:0];
				OFS_IRQ_STATUS: clr = reg_wdata[IRQ_W-1:0];
				OFS_IRQ_MASK: d.irq_mask = reg_wdata[IRQ_W-1:0];
				// unmapped writes are dropped
				default: ;
			endcase
		end

		// register reads answer in the next cycle only; unmapped reads give zero
		d.rdata = '0;
		if (reg_read) begin
			unique case (reg_addr)
				OFS_CTRL: d.rdata = ctrl_word(q);
				OFS_LEN: d.rdata[LEN_W-1:0] = q.cfg_len;
				OFS_IRQ_STATUS: d.rdata[IRQ_W-1:0] = q.irq_st;
				OFS_IRQ_MASK: d.rdata[IRQ_W-1:0] = q.irq_mask;
				OFS_STATE: d.rdata = state_word(q);
				default: d.rdata = '0;
			endcase
		end

		// result store, only while the framer is not sending
		if (res_wr && q.res_ready && (res_waddr < 8'(DATA_MAX))) begin
			d.mem[res_waddr] = res_wdata;
		end
		if (res_commit && q.res_ready) begin
			d.r_len = res_length;
			d.r_cnt = res_count;
			d.r_flags[FLG_ACT] = res_activation;
			d.r_flags[FLG_USER] = res_user_cmd;
			d.r_flags[FLG_MORE] = res_more;
			d.r_flags[FLG_OVF] = res_overflow;
			d.r_flags[FLG_WAIT] = res_wait_ack;
			// an edge, not a level: the controller compares it between cycles
			d.r_flags[FLG_NEW] = ~q.r_flags[FLG_NEW];
			evt[IRQ_RESULT] = 1'b1;
		end

		// acceptance and rejection are toggles for the same reason
		d.acc_t = q.acc_t ^ accept_evt;
		d.rej_t = q.rej_t ^ reject_evt;

		// frame requests; a request while one already waits is counted as missed
		if (start_now) begin
			d.pend = 1'b0;
		end
		if (frame_req) begin
			// merged: the image is cyclic, so one frame serves both requests
			if (q.pend && !start_now) begin
				evt[IRQ_MISSED] = 1'b1;
			end
			d.pend = 1'b1;
		end

		// frame sequencer
		unique case (q.run)
			RUN_IDLE: begin
				// byte 0 comes from the live header, as the snapshot lands on this same edge
				if (start_now) begin
					d.run = RUN_SEND;
					d.hdr = live;
					d.len = frame_len;
					d.pos = '0;
					d.data = pk.byte_out;
					d.valid = 1'b1;
					d.first = 1'b1;
					d.last = (frame_len == IMG_MIN);
				end
			end
			RUN_SEND: begin
				// without ready the byte and its marks simply stay put
				if (img_ready) begin
					if (q.last) begin
						d.run = RUN_IDLE;
						d.valid = 1'b0;
						d.first = 1'b0;
						d.last = 1'b0;
						evt[IRQ_FRAME_SENT] = 1'b1;
					end else begin
						d.pos = step_pos(q.pos, 9'h001);
						d.data = pk.byte_out;
						d.first = 1'b0;
						d.last = (step_pos(q.pos, 9'h002) == q.len);
					end
				end
			end
		endcase

		// new events win over a clear in the same cycle
		d.irq_st = (q.irq_st & ~clr) | evt;
		d.irq = irq_level(d.irq_st, d.irq_mask);
		// the store opens again on the edge at which the last byte leaves
		d.res_ready = (d.run == RUN_IDLE);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// every output is a register field, with no logic after the flops
	assign reg_rdata = q.rdata;
	assign irq = q.irq;
	assign res_ready = q.res_ready;
	assign img_valid = q.valid;
	assign img_data = q.data;
	assign img_first = q.first;
	assign img_last = q.last;

endmodule
`default_nettype wire

// File: logic/image_pkg.sv
// shared constants and types for the scan result input image framer
`default_nettype none
package image_pkg;

	// register port
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_LEN = 8'h04;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
	localparam logic [7:0] OFS_STATE = 8'h10;

	// control and state register fields
	localparam int CTL_EN_BIT = 0;
	localparam int CTL_EXT_BIT = 1;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_TOGGLE_BIT = 1;
	localparam int ST_PEND_BIT = 2;
	localparam int ST_COUNT_LSB = 8;

	// interrupt events
	localparam int IRQ_W = 3;
	localparam int IRQ_FRAME_SENT = 0;
	localparam int IRQ_RESULT = 1;
	localparam int IRQ_MISSED = 2;

	// image lengths
	localparam int LEN_W = 9;
	localparam logic [8:0] IMG_MIN = 9'h001;
	localparam logic [8:0] IMG_MAX_COMPACT = 9'h104;
	localparam logic [8:0] IMG_MAX_EXT = 9'h108;
	localparam logic [8:0] HDR_COMPACT = 9'h005;
	localparam logic [8:0] HDR_EXT = 9'h009;
	localparam int DATA_MAX = 255;

	// byte positions, compact image
	localparam logic [8:0] C_DEV = 9'h000;
	localparam logic [8:0] C_COUNT = 9'h001;
	localparam logic [8:0] C_FLAGS = 9'h002;
	localparam logic [8:0] C_LEN_LO = 9'h003;
	localparam logic [8:0] C_LEN_HI = 9'h004;

	// byte positions, extended image
	localparam logic [8:0] E_DEV = 9'h000;
	localparam logic [8:0] E_ACK = 9'h001;
	localparam logic [8:0] E_FRAG_NUM = 9'h002;
	localparam logic [8:0] E_FRAG_REM = 9'h003;
	localparam logic [8:0] E_FRAG_SIZE = 9'h004;
	localparam logic [8:0] E_COUNT = 9'h005;
	localparam logic [8:0] E_FLAGS = 9'h006;
	localparam logic [8:0] E_LEN_LO = 9'h007;
	localparam logic [8:0] E_LEN_HI = 9'h008;

	// result status bits
	localparam int FLG_W = 6;
	localparam int FLG_ACT = 0;
	localparam int FLG_USER = 1;
	localparam int FLG_MORE = 2;
	localparam int FLG_OVF = 3;
	localparam int FLG_NEW = 4;
	localparam int FLG_WAIT = 5;

	// acknowledge byte bits
	localparam int ACK_ACCEPT = 0;
	localparam int ACK_REJECT = 1;
	localparam int ACK_ERR_LSB = 4;
	localparam int ERR_W = 3;

	typedef enum logic {RUN_IDLE, RUN_SEND} run_type;

	typedef struct packed {
		logic ext;
		logic [7:0] dev_status;
		logic [7:0] ack;
		logic [7:0] frag_num;
		logic [7:0] frag_rem;
		logic [7:0] frag_size;
		logic [7:0] count;
		logic [FLG_W-1:0] flags;
		logic [15:0] res_len;
	} hdr_type;

	function automatic logic [8:0] clamp_len(input logic [8:0] v, input logic ext);
		logic [8:0] top;
		top = ext ? IMG_MAX_EXT : IMG_MAX_COMPACT;
		if (v < IMG_MIN) begin
			return IMG_MIN;
		end
		return (v > top) ? top : v;
	endfunction

endpackage
`default_nettype wire

// File: logic/pick_if.sv
// link between the framer and its byte picker
`default_nettype none
interface pick_if;
	import image_pkg::*;
	hdr_type hdr;
	logic [8:0] idx;
	logic [7:0] mem_idx;
	logic [7:0] mem_byte;
	logic [7:0] byte_out;
	modport framer (output hdr, output idx, output mem_byte, input mem_idx, input byte_out);
	modport picker (input hdr, input idx, input mem_byte, output mem_idx, output byte_out);
endinterface
`default_nettype wire

// File: logic/image_byte_picker.sv
// selects the image byte at a given position for either layout
`default_nettype none
module image_byte_picker
	import image_pkg::*;
(
	pick_if.picker pk
);

	logic [8:0] hdr_len;
	logic [8:0] didx;
	logic in_data;
	logic [7:0] flags_byte;

	always_comb begin
		hdr_len = pk.hdr.ext ? HDR_EXT : HDR_COMPACT;
		didx = 9'(pk.idx - hdr_len);
		in_data = (pk.idx >= hdr_len);
		// top two status bits stay reserved at zero
		flags_byte = {2'h0, pk.hdr.flags};
		pk.mem_idx = 8'h00;
		pk.byte_out = 8'h00;
		if (in_data) begin
			// data begins right after the header; bytes past the result read as zero
			if ((didx < 9'(DATA_MAX)) && ({7'h00, didx} < pk.hdr.res_len)) begin
				pk.mem_idx = didx[7:0];
				pk.byte_out = pk.mem_byte;
			end
		end else if (!pk.hdr.ext) begin
			unique case (pk.idx)
				C_DEV: pk.byte_out = pk.hdr.dev_status;
				C_COUNT: pk.byte_out = pk.hdr.count;
				C_FLAGS: pk.byte_out = flags_byte;
				C_LEN_LO: pk.byte_out = pk.hdr.res_len[7:0];
				C_LEN_HI: pk.byte_out = pk.hdr.res_len[15:8];
				default: pk.byte_out = 8'h00;
			endcase
		end else begin
			unique case (pk.idx)
				E_DEV: pk.byte_out = pk.hdr.dev_status;
				E_ACK: pk.byte_out = pk.hdr.ack;
				E_FRAG_NUM: pk.byte_out = pk.hdr.frag_num;
				E_FRAG_REM: pk.byte_out = pk.hdr.frag_rem;
				E_FRAG_SIZE: pk.byte_out = pk.hdr.frag_size;
				E_COUNT: pk.byte_out = pk.hdr.count;
				E_FLAGS: pk.byte_out = flags_byte;
				E_LEN_LO: pk.byte_out = pk.hdr.res_len[7:0];
				E_LEN_HI: pk.byte_out = pk.hdr.res_len[15:8];
				default: pk.byte_out = 8'h00;
			endcase
		end
	end

endmodule
`default_nettype wire

// File: test/image_framer_properties.sv
// port-level assertions for the input image framer
`default_nettype none
module image_framer_properties (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// register read
	input wire logic reg_read,
	input wire logic [31:0] reg_rdata,
	// stream
	input wire logic res_ready,
	input wire logic img_ready,
	input wire logic img_valid,
	input wire logic [7:0] img_data,
	input wire logic img_first,
	input wire logic img_last
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] pos_q;
	// byte position inside the frame, counted from accepted bytes only
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pos_q <= 9'h000;
		end else if (img_valid && img_ready) begin
			pos_q <= img_last ? 9'h000 : pos_q + 9'h001;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	AST_FIRST_START:
		assert property ($rose(img_valid) |-> img_first) else $error("frame opened without first mark");
	AST_HOLD:
		assert property (img_valid && !img_ready |=> img_valid && $stable(img_data) && $stable(img_last))
			else $error("byte changed while stalled");
	AST_LAST_DROP:
		assert property (img_valid && img_ready && img_last |=> !img_valid && res_ready)
			else $error("frame end not followed by idle");
	AST_BUSY:
		assert property (img_valid |-> !res_ready) else $error("result store open during frame");
	AST_FIRST_AT_ZERO:
		assert property (img_valid && img_first |-> pos_q == 9'h000) else $error("first mark off byte 0");
	AST_NEXT_NOT_FIRST:
		assert property (img_valid && img_ready && !img_last |=> !img_first) else $error("frame restarted");
	AST_MAX_LEN:
		assert property (img_valid && img_ready |-> pos_q < 9'h108) else $error("frame longer than 264");
	AST_RDATA_IDLE:
		assert property (!$past(reg_read) |-> reg_rdata == 32'h0) else $error("read data outside slot");
	COV_FRAME: cover property (img_valid && img_ready && img_last);
	COV_STALL: cover property (img_valid && !img_ready);
	COV_READ: cover property (reg_rdata != 32'h0);
endmodule
`default_nettype wire

// File: test/image_consumer.sv
// controller-side consumer of the input image stream
`default_nettype none
module image_consumer (
	// stream
	input wire logic ref_clk,
	input wire logic img_valid,
	input wire logic [7:0] img_data,
	input wire logic img_first,
	output logic img_ready,
	input wire logic img_last,
	// mode and status
	input wire logic stall,
	output int n,
	output int frames
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got [0:299];
	initial begin
		img_ready = 1'b0;
		n = 0;
		frames = 0;
	end
	// takes a byte only on valid and ready; slow mode halves the rate
	always @(posedge ref_clk) begin
		if (img_valid && img_ready) begin
			got[img_first ? 0 : n] <= img_data;
			n <= img_first ? 1 : n + 1;
			frames <= frames + (img_last ? 1 : 0);
		end
		img_ready <= stall ? !img_ready : 1'b1;
	end
endmodule
`default_nettype wire

// File: test/tb_scan_result_input_image_framer.sv
// self-checking bench for the input image framer
`default_nettype none
module tb_scan_result_input_image_framer;
	import image_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, reset_n, reg_write, reg_read, irq, res_wr, res_commit, res_ready, stall;
	logic res_activation, res_user_cmd, res_more, res_overflow, res_wait_ack;
	logic accept_evt, reject_evt, frame_req, img_ready, img_valid, img_first, img_last;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata;
	logic [7:0] res_waddr, res_wdata, res_count, dev_status, frag_num, frag_rem, frag_size, img_data;
	logic [15:0] res_length;
	logic [ERR_W-1:0] err_code;
	logic [7:0] exp_img [0:299];
	int errors = 0;
	int total_checks = 0;
	scan_result_input_image_framer dut (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
		.reg_rdata, .irq, .res_wr, .res_waddr, .res_wdata, .res_commit, .res_length, .res_count,
		.res_activation, .res_user_cmd, .res_more, .res_overflow, .res_wait_ack, .res_ready, .dev_status,
		.accept_evt, .reject_evt, .err_code, .frag_num, .frag_rem, .frag_size, .frame_req, .img_ready,
		.img_valid, .img_data, .img_first, .img_last);
	image_consumer u_con (.ref_clk, .img_valid, .img_data, .img_first, .img_ready, .img_last, .stall,
		.n(), .frames());
	task automatic report_and_stop;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge ref_clk);
		reg_write <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge ref_clk);
		reg_read <= 1'b0;
		#1 chk("register", reg_rdata, e);
		@(posedge ref_clk);
	endtask
	task automatic pulse_evt(input logic rej);
		accept_evt <= !rej;
		reject_evt <= rej;
		@(posedge ref_clk);
		accept_evt <= 1'b0;
		reject_evt <= 1'b0;
	endtask
	// stores len data bytes and commits them with count and status bits
	task automatic load(input int len, input logic [7:0] cnt, input logic [4:0] f);
		for (int i = 0; i < len; i++) begin
			res_wr <= 1'b1;
			res_waddr <= 8'(i);
			res_wdata <= 8'hA0 + 8'(i);
			@(posedge ref_clk);
		end
		res_wr <= 1'b0;
		res_commit <= 1'b1;
		res_length <= 16'(len);
		res_count <= cnt;
		{res_wait_ack, res_overflow, res_more, res_user_cmd, res_activation} <= f;
		@(posedge ref_clk);
		res_commit <= 1'b0;
	endtask
	task automatic expect_img(input logic ext, input logic [7:0] b1, input logic [7:0] cnt, input logic [7:0] f);
		int h;
		h = ext ? 9 : 5;
		for (int i = 0; i < 300; i++) begin
			exp_img[i] = (i >= h && i - h < 10) ? 8'hA0 + 8'(i - h) : 8'h00;
		end
		exp_img[0] = 8'h5A;
		exp_img[h-4] = cnt;
		exp_img[h-3] = f;
		exp_img[h-2] = 8'h0A;
		if (ext) begin
			exp_img[1] = b1;
			exp_img[2] = 8'h01;
			exp_img[3] = 8'h02;
			exp_img[4] = 8'h03;
		end
	endtask
	task automatic frame(input int n);
		int f0;
		f0 = u_con.frames;
		frame_req <= 1'b1;
		@(posedge ref_clk);
		frame_req <= 1'b0;
		for (int t = 0; t < 2000 && u_con.frames == f0; t++) begin
			@(posedge ref_clk);
		end
		chk("frame length", 32'(u_con.n), 32'(n));
		for (int i = 0; i < n; i++) begin
			chk("image byte", {24'h0, u_con.got[i]}, {24'h0, exp_img[i]});
		end
		repeat (3) @(posedge ref_clk);
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		report_and_stop();
	end
	initial begin
		{reg_write, reg_read, res_wr, res_commit, accept_evt, reject_evt, frame_req, stall} = '0;
		{res_activation, res_user_cmd, res_more, res_overflow, res_wait_ack} = '0;
		{reg_addr, reg_wdata, res_waddr, res_wdata, res_length, res_count} = '0;
		{dev_status, frag_num, frag_rem, frag_size, err_code} = {8'h5A, 8'h01, 8'h02, 8'h03, 3'h5};
		reset_n = 1'b0;
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rd(OFS_CTRL, 32'h0);
		rd(OFS_STATE, 32'h0);
		rd(8'h14, 32'h0);
		load(10, 8'h01, 5'b10101);
		rd(OFS_STATE, 32'h0102);
		wr(OFS_CTRL, 32'h1);
		wr(OFS_LEN, 32'(HDR_COMPACT) + 32'd10);
		expect_img(1'b0, 8'h00, 8'h01, 8'h35);
		frame(15);
		pulse_evt(1'b0);
		load(10, 8'h02, 5'b00000);
		rd(OFS_STATE, 32'h0200);
		stall <= 1'b1;
		wr(OFS_CTRL, 32'h3);
		wr(OFS_LEN, 32'(HDR_EXT) + 32'd10);
		expect_img(1'b1, 8'h51, 8'h02, 8'h00);
		frame(19);
		pulse_evt(1'b1);
		expect_img(1'b1, 8'h53, 8'h02, 8'h00);
		wr(OFS_LEN, 32'h0);
		frame(1);
		wr(OFS_LEN, 32'h1FF);
		frame(264);
		wr(OFS_CTRL, 32'h1);
		expect_img(1'b0, 8'h00, 8'h02, 8'h00);
		frame(260);
		#1 chk("irq", 32'(irq), 32'h0);
		rd(OFS_IRQ_STATUS, 32'h3);
		wr(OFS_IRQ_MASK, 32'h1);
		@(posedge ref_clk);
		#1 chk("irq", 32'(irq), 32'h1);
		wr(OFS_IRQ_STATUS, 32'h7);
		@(posedge ref_clk);
		#1 chk("irq", 32'(irq), 32'h0);
		rd(OFS_IRQ_STATUS, 32'h0);
		// disabled: a held request stays pending and its repeat counts as missed
		wr(OFS_CTRL, 32'h0);
		frame_req <= 1'b1;
		repeat (2) @(posedge ref_clk);
		frame_req <= 1'b0;
		rd(OFS_STATE, 32'h0204);
		rd(OFS_IRQ_STATUS, 32'h4);
		report_and_stop();
	end
endmodule
bind scan_result_input_image_framer image_framer_properties u_props (.ref_clk, .reset_n, .reg_read, .reg_rdata,
	.res_ready, .img_ready, .img_valid, .img_data, .img_first, .img_last);
`default_nettype wire
